// ### hdl/pbc_ctrl.sv
// Host bridge control and PCI arbiter driven by control register two and arbitration register one.
// Operation
// (RULE_01) Bit 6 of control two shows internal clock activity on a debug output.
// (RULE_02) Bit 5 makes the master drive SERR# whenever it drives or sees PERR#.
// (RULE_03) Bit 4 posts non-locked memory writes; I/O and locked cycles never post.
// (RULE_04) Target disconnects bursts at 128, 256, 512 or 1024 byte boundaries per bits 3:2.
// (RULE_05) Bit 1 replaces that boundary with the 16-byte cache line boundary.
// (RULE_06) Bit 0 adds wait states to target-originated internal-bus writes.
// (RULE_07) Arbiter bit 7 grants only when internal-bus write buffers are empty.
// (RULE_08) Arbiter bits 5, 4, 3 enable retry masking of lines 2, 1, 0.
// (RULE_09) Bits 2:1 choose mask length: none, 16, 32 or 64 PCI clocks.
// (RULE_10) Arbiter bit 0 keeps internal-bus hold two more clocks after a retry.
// (RULE_11) Control two resets to 96h.
// (RULE_12) Arbitration one resets to 80h.
// (RULE_13) Mask length counts from the clock the retry is seen.
`timescale 1ns/1ps
`default_nettype none
module pbc_ctrl #(
	parameter int WRITE_WAIT_STATES = pbc_pkg::WRITE_WAIT_DEFAULT,
	parameter int REQ_LINES = 3
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Configuration port.
	input wire pbc_pkg::pbc_cfg_req_t cfg_req,
	output logic [7:0] cfg_rdata,
	output logic cfg_rvalid,
	// Debug clock view.
	output logic raw_clk_view,
	// Parity reporting as master.
	input wire logic master_active,
	input wire logic perr_driven,
	input wire logic perr_seen,
	output logic serr_o,
	output logic serr_oe_n,
	// Internal-bus write to PCI master path.
	input wire logic xb_wr_valid,
	input wire logic xb_wr_is_mem,
	input wire logic xb_wr_locked,
	output logic xb_wr_post,
	// PCI target burst.
	input wire logic tgt_burst_active,
	input wire logic [11:0] tgt_addr,
	output logic tgt_disconnect,
	// Target write onto the internal bus.
	input wire logic xb_tgt_write_start,
	output logic xb_write_wait,
	// Arbitration.
	input wire logic [REQ_LINES-1:0] req_n,
	input wire logic xb_bufs_empty,
	input wire logic retry_seen,
	output logic [REQ_LINES-1:0] gnt_n,
	output logic xb_hold
);

	// Refuse settings that the three-line grant logic and the four-bit wait counter cannot serve.
	if (REQ_LINES != 3) begin : g_bad_lines
		$error("REQ_LINES must be 3");
	end
	if (WRITE_WAIT_STATES < 1 || WRITE_WAIT_STATES > 15) begin : g_bad_wait
		$error("WRITE_WAIT_STATES must be 1..15");
	end

	pbc_pkg::pbc_ctrl_two_t ctrl_two;
	pbc_pkg::pbc_arb_one_t arb_one;
	logic [REQ_LINES-1:0] masked;
	logic [REQ_LINES-1:0] eligible;
	logic [REQ_LINES-1:0] owner;
	logic [REQ_LINES-1:0] next_owner;
	logic [3:0] wait_cnt;
	logic [1:0] hold_extra;

	// Word-offset mask of the active disconnect boundary; all ones marks the last word before it.
	function automatic logic [7:0] boundary_mask(input logic [1:0] sel, input logic line_en);
		if (line_en) begin
			boundary_mask = 8'(pbc_pkg::LINE_BYTES / 4 - 1); // RULE_05
		end else begin
			case (sel)
				pbc_pkg::BOUND_128: boundary_mask = 8'h1f; // RULE_04
				pbc_pkg::BOUND_256: boundary_mask = 8'h3f;
				pbc_pkg::BOUND_512: boundary_mask = 8'h7f;
				pbc_pkg::BOUND_1024: boundary_mask = 8'hff;
				default: boundary_mask = 8'hff;
			endcase
		end
	endfunction

	// Configuration writes.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ctrl_two <= pbc_pkg::CTRL_TWO_RESET; // RULE_11
			arb_one <= pbc_pkg::ARB_ONE_RESET; // RULE_12
		end else if (cfg_req.wr) begin
			if (cfg_req.index == pbc_pkg::IDX_CTRL_TWO) begin
				ctrl_two <= cfg_req.wdata & pbc_pkg::CTRL_TWO_WMASK;
			end
			if (cfg_req.index == pbc_pkg::IDX_ARB_ONE) begin
				arb_one <= (cfg_req.wdata & pbc_pkg::ARB_ONE_WMASK) | pbc_pkg::ARB_ONE_FIXED;
			end
		end
	end

	// Configuration reads answer one clock later; unknown indices read zero.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cfg_rdata <= 8'h00;
			cfg_rvalid <= 1'b0;
		end else begin
			cfg_rvalid <= cfg_req.rd;
			case (cfg_req.index)
				pbc_pkg::IDX_CTRL_TWO: cfg_rdata <= ctrl_two;
				pbc_pkg::IDX_RESERVED: cfg_rdata <= pbc_pkg::RESERVED_VALUE;
				pbc_pkg::IDX_ARB_ONE: cfg_rdata <= arb_one;
				default: cfg_rdata <= 8'h00;
			endcase
		end
	end

	// Debug view toggles every clock while enabled.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			raw_clk_view <= 1'b0;
		end else begin
			raw_clk_view <= ctrl_two.raw_clk_en ? ~raw_clk_view : 1'b0; // RULE_01
		end
	end

	// SERR# is open drain: driven low while enabled and a master parity error occurs.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			serr_o <= 1'b0;
			serr_oe_n <= 1'b1;
		end else begin
			serr_o <= 1'b0;
			serr_oe_n <= ~(ctrl_two.parity_forces_syserr && master_active && (perr_driven || perr_seen)); // RULE_02
		end
	end

	// Posting decision for each internal-bus write.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			xb_wr_post <= 1'b0;
		end else begin
			xb_wr_post <= xb_wr_valid && ctrl_two.master_write_post_en && xb_wr_is_mem && !xb_wr_locked; // RULE_03
		end
	end

	// Disconnect when the current data phase is the last one before the boundary.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tgt_disconnect <= 1'b0;
		end else begin
			tgt_disconnect <= tgt_burst_active && ((tgt_addr[9:2] & boundary_mask(ctrl_two.target_disconnect_boundary,
				ctrl_two.line_boundary_disconnect_en)) == boundary_mask(ctrl_two.target_disconnect_boundary,
				ctrl_two.line_boundary_disconnect_en)); // RULE_04 RULE_05
		end
	end

	// Wait-state insertion on target writes to the internal bus.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wait_cnt <= 4'h0;
			xb_write_wait <= 1'b0;
		end else if (xb_tgt_write_start && ctrl_two.internal_write_wait_en) begin
			wait_cnt <= 4'(WRITE_WAIT_STATES - 1); // RULE_06
			xb_write_wait <= 1'b1;
		end else if (wait_cnt != 4'h0) begin
			wait_cnt <= wait_cnt - 4'h1;
		end else begin
			xb_write_wait <= 1'b0;
		end
	end

	// Retry masking per request line.
	pbc_retry_mask #(
		.LINES(REQ_LINES)
	) u_mask (
		.clk(clk),
		.reset_n(reset_n),
		.retry_seen(retry_seen),
		.owner(owner),
		.line_en({arb_one.retry_mask_en_line2, arb_one.retry_mask_en_line1, arb_one.retry_mask_en_line0}), // RULE_08
		.period(arb_one.retry_mask_period),
		.masked(masked)
	);

	// Fixed-order grant; owner keeps the bus until it drops its request or is retried.
	always_comb begin
		eligible = ~req_n & ~masked; // RULE_08
		next_owner = owner;
		if (retry_seen || (owner & ~req_n) == '0) begin
			next_owner = '0;
			if (!arb_one.grant_when_buffers_empty || xb_bufs_empty) begin // RULE_07
				if (eligible[0]) begin
					next_owner = 3'b001;
				end else if (eligible[1]) begin
					next_owner = 3'b010;
				end else if (eligible[2]) begin
					next_owner = 3'b100;
				end
			end
			if (retry_seen) begin
				next_owner = '0;
			end
		end
	end

	// Grant state and outputs.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			owner <= '0;
			gnt_n <= '1;
		end else begin
			owner <= next_owner;
			gnt_n <= ~next_owner;
		end
	end

	// Internal-bus hold while a master owns the bus, extended after a retry.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			hold_extra <= 2'h0;
			xb_hold <= 1'b0;
		end else begin
			if (retry_seen && arb_one.hold_after_retry_en) begin
				hold_extra <= pbc_pkg::HOLD_EXTRA_CLOCKS; // RULE_10
			end else if (hold_extra != 2'h0) begin
				hold_extra <= hold_extra - 2'h1;
			end
			xb_hold <= (next_owner != '0) || (retry_seen && arb_one.hold_after_retry_en) || (hold_extra > 2'h1);
		end
	end

endmodule // pbc_ctrl
`default_nettype wire

// ### pkg/pbc_pkg.sv
// Shared constants and register layouts for the bridge control and arbiter block.
package pbc_pkg;

	// Configuration indices.
	localparam logic [7:0] IDX_CTRL_TWO = 8'h41;
	localparam logic [7:0] IDX_RESERVED = 8'h42;
	localparam logic [7:0] IDX_ARB_ONE = 8'h43;

	// Reset values.
	localparam logic [7:0] CTRL_TWO_RESET = 8'h96;
	localparam logic [7:0] ARB_ONE_RESET = 8'h80;
	localparam logic [7:0] RESERVED_VALUE = 8'h00;

	// Writable bit masks; once written, bit 7 of control two reads 0 and bit 6 of arbiter one reads 1.
	localparam logic [7:0] CTRL_TWO_WMASK = 8'h7f;
	localparam logic [7:0] ARB_ONE_WMASK = 8'hbf;
	localparam logic [7:0] ARB_ONE_FIXED = 8'h40;

	// Disconnect boundary codes and sizes in bytes.
	localparam logic [1:0] BOUND_128 = 2'h0;
	localparam logic [1:0] BOUND_256 = 2'h1;
	localparam logic [1:0] BOUND_512 = 2'h2;
	localparam logic [1:0] BOUND_1024 = 2'h3;
	localparam int LINE_BYTES = 16;

	// Retry mask period codes and counts in PCI clocks.
	localparam logic [1:0] MASK_NONE = 2'h0;
	localparam logic [1:0] MASK_16 = 2'h1;
	localparam logic [1:0] MASK_32 = 2'h2;
	localparam logic [1:0] MASK_64 = 2'h3;
	localparam logic [6:0] MASK_CLOCKS_16 = 7'h10;
	localparam logic [6:0] MASK_CLOCKS_32 = 7'h20;
	localparam logic [6:0] MASK_CLOCKS_64 = 7'h40;

	// Extra internal-bus hold clocks after a retry.
	localparam logic [1:0] HOLD_EXTRA_CLOCKS = 2'h2;

	// Default internal-bus write wait states.
	localparam int WRITE_WAIT_DEFAULT = 1;

	// Control register two layout.
	typedef struct packed {
		logic rsvd;
		logic raw_clk_en;
		logic parity_forces_syserr;
		logic master_write_post_en;
		logic [1:0] target_disconnect_boundary;
		logic line_boundary_disconnect_en;
		logic internal_write_wait_en;
	} pbc_ctrl_two_t;

	// Arbitration control register one layout.
	typedef struct packed {
		logic grant_when_buffers_empty;
		logic rsvd;
		logic retry_mask_en_line2;
		logic retry_mask_en_line1;
		logic retry_mask_en_line0;
		logic [1:0] retry_mask_period;
		logic hold_after_retry_en;
	} pbc_arb_one_t;

	// Configuration access request.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] index;
		logic [7:0] wdata;
	} pbc_cfg_req_t;

endpackage

// ### hdl/pbc_retry_mask.sv
// Per-line request masking counters for masters that were retried.
`timescale 1ns/1ps
`default_nettype none
module pbc_retry_mask #(
	parameter int LINES = 3
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Retry event and the line that owned the bus.
	input wire logic retry_seen,
	input wire logic [LINES-1:0] owner,
	// Configuration.
	input wire logic [LINES-1:0] line_en,
	input wire logic [1:0] period,
	// Lines currently ignored.
	output logic [LINES-1:0] masked
);

	logic [6:0] cnt [LINES];

	// Decodes the period code into a clock count.
	function automatic logic [6:0] period_clocks(input logic [1:0] code);
		case (code)
			pbc_pkg::MASK_16: period_clocks = pbc_pkg::MASK_CLOCKS_16;
			pbc_pkg::MASK_32: period_clocks = pbc_pkg::MASK_CLOCKS_32;
			pbc_pkg::MASK_64: period_clocks = pbc_pkg::MASK_CLOCKS_64;
			default: period_clocks = 7'h00;
		endcase
	endfunction

	// Each counter loads on the retry clock and counts down to eligibility.
	always_ff @(posedge clk) begin
		for (int i = 0; i < LINES; i++) begin
			if (!reset_n) begin
				cnt[i] <= 7'h00;
			end else if (retry_seen && owner[i] && line_en[i]) begin
				cnt[i] <= period_clocks(period); // RULE_08 RULE_09 RULE_13
			end else if (cnt[i] != 7'h00) begin
				cnt[i] <= cnt[i] - 7'h01; // RULE_13
			end
		end
	end

	// A line is masked while its counter runs.
	always_comb begin
		for (int i = 0; i < LINES; i++) begin
			masked[i] = (cnt[i] != 7'h00); // RULE_09
		end
	end

endmodule // pbc_retry_mask
`default_nettype wire

// ### testbench/pbc_ctrl_asserts.sv
// Port checker for the bridge control and arbiter block.
`timescale 1ns/1ps
`default_nettype none
module pbc_ctrl_asserts #(
	parameter int REQ_LINES = 3
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Watched ports.
	input wire pbc_pkg::pbc_cfg_req_t cfg_req,
	input wire logic cfg_rvalid,
	input wire logic master_active,
	input wire logic perr_driven,
	input wire logic perr_seen,
	input wire logic serr_oe_n,
	input wire logic xb_wr_valid,
	input wire logic xb_wr_is_mem,
	input wire logic xb_wr_locked,
	input wire logic xb_wr_post,
	input wire logic tgt_burst_active,
	input wire logic [11:0] tgt_addr,
	input wire logic tgt_disconnect,
	input wire logic xb_tgt_write_start,
	input wire logic xb_write_wait,
	input wire logic [REQ_LINES-1:0] req_n,
	input wire logic retry_seen,
	input wire logic [REQ_LINES-1:0] gnt_n
);
	// All checks share the one clock and its reset.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	rd_answer_a: assert property (cfg_req.rd |=> cfg_rvalid)
		else $error("read not answered");
	gnt_single_a: assert property ($onehot0(~gnt_n))
		else $error("more than one grant");
	gnt_req_a: assert property ($changed(gnt_n) |-> (~gnt_n & $past(req_n)) == '0)
		else $error("grant without request");
	retry_free_a: assert property (retry_seen |=> &gnt_n)
		else $error("owner kept after retry");
	serr_cause_a: assert property (!serr_oe_n |-> $past(master_active && (perr_driven || perr_seen)))
		else $error("system error without parity error");
	post_cause_a: assert property (xb_wr_post |-> $past(xb_wr_valid && xb_wr_is_mem && !xb_wr_locked))
		else $error("wrong write posted");
	disc_cause_a: assert property (tgt_disconnect |-> $past(tgt_burst_active && (&tgt_addr[3:2])))
		else $error("disconnect off boundary");
	wait_cause_a: assert property ($rose(xb_write_wait) |-> $past(xb_tgt_write_start))
		else $error("wait without write");
endmodule // pbc_ctrl_asserts
bind pbc_ctrl pbc_ctrl_asserts #(.REQ_LINES(REQ_LINES)) u_chk (.clk(clk), .reset_n(reset_n),
	.cfg_req(cfg_req), .cfg_rvalid(cfg_rvalid), .master_active(master_active), .perr_driven(perr_driven),
	.perr_seen(perr_seen), .serr_oe_n(serr_oe_n), .xb_wr_valid(xb_wr_valid), .xb_wr_is_mem(xb_wr_is_mem),
	.xb_wr_locked(xb_wr_locked), .xb_wr_post(xb_wr_post), .tgt_burst_active(tgt_burst_active),
	.tgt_addr(tgt_addr), .tgt_disconnect(tgt_disconnect), .xb_tgt_write_start(xb_tgt_write_start),
	.xb_write_wait(xb_write_wait), .req_n(req_n), .retry_seen(retry_seen), .gnt_n(gnt_n));
`default_nettype wire

// ### testbench/pbc_pci_agents.sv
// Behavioural PCI masters and a retrying target facing the arbiter.
`timescale 1ns/1ps
`default_nettype none
module pbc_pci_agents (
	// Which masters want the bus, and a retry order.
	input wire logic [2:0] want,
	input wire logic do_retry,
	// Bus side.
	input wire logic [2:0] gnt_n,
	output logic [2:0] req_n,
	output logic retry_seen
);
	// A master holds its request while it wants the bus; a target only retries a current owner.
	assign req_n = ~want;
	assign retry_seen = do_retry && (gnt_n != 3'h7);
endmodule // pbc_pci_agents
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the bridge control and arbiter block.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk, reset_n, rvalid, raw, ma, pd, ps, serr, serr_oe_n, wv, wm, wl, post, ba, disc, ws, wt;
	logic empty, retry, hold, do_retry, r0;
	logic [2:0] req_n, gnt_n, want;
	logic [7:0] rdata, c2, ex;
	logic [11:0] addr;
	logic [31:0] seed, r;
	logic [1:0] p, ln;
	pbc_pkg::pbc_cfg_req_t cfg;
	int n_mismatch, compares, k;
	pbc_pci_agents u_agents (.want(want), .do_retry(do_retry), .gnt_n(gnt_n), .req_n(req_n), .retry_seen(retry));
	pbc_ctrl #(.WRITE_WAIT_STATES(1), .REQ_LINES(3)) dut (.clk(clk), .reset_n(reset_n), .cfg_req(cfg),
		.cfg_rdata(rdata), .cfg_rvalid(rvalid), .raw_clk_view(raw), .master_active(ma), .perr_driven(pd),
		.perr_seen(ps), .serr_o(serr), .serr_oe_n(serr_oe_n), .xb_wr_valid(wv), .xb_wr_is_mem(wm),
		.xb_wr_locked(wl), .xb_wr_post(post), .tgt_burst_active(ba), .tgt_addr(addr), .tgt_disconnect(disc),
		.xb_tgt_write_start(ws), .xb_write_wait(wt), .req_n(req_n), .xb_bufs_empty(empty),
		.retry_seen(retry), .gnt_n(gnt_n), .xb_hold(hold));
	// Free-running clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Hang guard.
	initial begin
		#400000;
		n_mismatch++;
		conclude();
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Disconnect when the byte address is the last word before the selected boundary.
	function automatic logic exp_disc(logic [7:0] c, logic b, logic [11:0] a);
		logic [10:0] m;
		m = c[1] ? 11'h00c : ((11'h080 << c[3:2]) - 11'h004);
		return b && (({1'b0, a[9:0]} & m) == m);
	endfunction
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		@(negedge clk);
		cfg = {1'b1, 1'b0, i, d};
		@(negedge clk);
		cfg = '0;
	endtask
	task automatic rdc(input logic [7:0] i, input logic [7:0] e);
		@(negedge clk);
		cfg = {1'b0, 1'b1, i, 8'h00};
		@(negedge clk);
		cfg = '0;
		chk1("rvalid", 1'b1, rvalid);
		chk("rdata", e, rdata);
	endtask
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Main sequence.
	initial begin
		seed = 32'h00017d9a;
		{reset_n, ma, pd, ps, wv, wm, wl, ba, ws, empty, do_retry} = '0;
		n_mismatch = 0;
		compares = 0;
		cfg = '0;
		addr = 12'h000;
		want = 3'h0;
		repeat (5) @(negedge clk);
		reset_n = 1'b1;
		rdc(pbc_pkg::IDX_CTRL_TWO, pbc_pkg::CTRL_TWO_RESET);
		rdc(pbc_pkg::IDX_ARB_ONE, pbc_pkg::ARB_ONE_RESET);
		wr(pbc_pkg::IDX_RESERVED, 8'hff);
		rdc(pbc_pkg::IDX_RESERVED, pbc_pkg::RESERVED_VALUE);
		// Random settings and bus activity, with a boundary hit forced half the time.
		for (int i = 0; i < 60; i++) begin
			r = xs();
			c2 = r[7:0];
			wr(pbc_pkg::IDX_CTRL_TWO, c2);
			r = xs();
			{ma, pd, ps, wv, wm, wl, ba, ws} = r[7:0];
			addr = r[19:8];
			if (r[20])
				addr[9:2] = 8'hff;
			@(negedge clk);
			r0 = raw;
			chk1("serr_oe_n", ~(c2[5] & ma & (pd | ps)), serr_oe_n);
			chk1("serr_o", 1'b0, serr);
			chk1("post", c2[4] & wv & wm & ~wl, post);
			chk1("disc", exp_disc(c2, ba, addr), disc);
			chk1("wait", c2[0] & ws, wt);
			ws = 1'b0;
			@(negedge clk);
			chk1("wait_end", 1'b0, wt);
			chk1("raw", c2[6] & ~r0, raw);
		end
		wr(pbc_pkg::IDX_ARB_ONE, 8'h00);
		rdc(pbc_pkg::IDX_ARB_ONE, pbc_pkg::ARB_ONE_FIXED);
		// Grants held back by full buffers only while the gating bit is set.
		wr(pbc_pkg::IDX_ARB_ONE, 8'h80);
		want = 3'h1;
		repeat (4) @(negedge clk);
		chk("gnt_full", 8'h07, {5'h0, gnt_n});
		empty = 1'b1;
		repeat (3) @(negedge clk);
		chk("gnt_empty", 8'h06, {5'h0, gnt_n});
		want = 3'h0;
		empty = 1'b0;
		// Retry with the requester gone: hold lingers only when enabled.
		for (int h = 1; h >= 0; h--) begin
			wr(pbc_pkg::IDX_ARB_ONE, {7'h0, h[0]});
			want = 3'h1;
			repeat (3) @(negedge clk);
			chk("gnt_any", 8'h06, {5'h0, gnt_n});
			want = 3'h0;
			do_retry = 1'b1;
			@(negedge clk);
			do_retry = 1'b0;
			chk1("hold_first", h[0], hold);
			@(negedge clk);
			chk1("hold", h[0], hold);
			@(negedge clk);
			chk1("hold_end", 1'b0, hold);
		end
		// Every mask period on line 0, then an unmasked line 1.
		for (int t = 0; t < 5; t++) begin
			p = (t == 4) ? 2'h3 : t[1:0];
			ln = (t == 4) ? 2'h1 : 2'h0;
			wr(pbc_pkg::IDX_ARB_ONE, {5'h01, p, 1'b0});
			want = 3'h1 << ln;
			repeat (3) @(negedge clk);
			do_retry = 1'b1;
			@(negedge clk);
			do_retry = 1'b0;
			k = 1;
			@(negedge clk);
			while (gnt_n !== ~want && k < 100) begin
				@(negedge clk);
				k++;
			end
			// The first free decision comes one clock after the mask period ends.
			ex = (ln != 2'h0 || p == 2'h0) ? 8'h01 : (8'h08 << p) + 8'h01;
			chk("regrant", ex, k[7:0]);
			want = 3'h0;
			repeat (3) @(negedge clk);
		end
		conclude();
	end
endmodule // tb
`default_nettype wire
